// ==== eitp_pkg.sv ====
// Package for the three-channel 8-bit interval timer
package eitp_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [11:0] EITP_ADDR_CH2_MODE = 12'hf90;
    localparam logic [11:0] EITP_ADDR_CTRL = 12'hf92;
    localparam logic [11:0] EITP_ADDR_CH0_MODE = 12'hfa0;
    localparam logic [11:0] EITP_ADDR_CH1_MODE = 12'hfa8;
    localparam logic [11:0] EITP_ADDR_CH0_MOD = 12'hfa4;
    localparam logic [11:0] EITP_ADDR_CH1_MOD = 12'hfac;
    localparam logic [11:0] EITP_ADDR_CH2_MOD = 12'hf94;
    localparam logic [11:0] EITP_ADDR_CH2_HMOD = 12'hf96;
    localparam logic [11:0] EITP_ADDR_CH0_CNT = 12'hfa2;
    localparam logic [11:0] EITP_ADDR_CH1_CNT = 12'hfaa;
    localparam logic [11:0] EITP_ADDR_CH2_CNT = 12'hf98;
    localparam logic [11:0] EITP_ADDR_OUT_EN = 12'hf9a;
    localparam logic [11:0] EITP_ADDR_START = 12'hf9c;
    localparam logic [11:0] EITP_ADDR_STATUS = 12'hf9e;
    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int EITP_BIT_START = 3;
    localparam int EITP_BIT_RUN = 2;
    localparam int EITP_BIT_CTRL_OE2 = 3;
    localparam logic [7:0] EITP_MODE_RESET = 8'h00;
    localparam logic [7:0] EITP_CTRL_RESET = 8'h00;
    localparam logic [7:0] EITP_MOD_RESET = 8'hff;
    localparam int EITP_PRESCALE_W = 12;
    // ----------------------------------------
    // Mode field codes
    // ----------------------------------------
    typedef enum logic [1:0] {
        EITP_MODE_8BIT = 2'b00,
        EITP_MODE_PWM = 2'b01,
        EITP_MODE_16BIT = 2'b10,
        EITP_MODE_CARRIER = 2'b11
    } eitp_mode_t;
    // Register bus request
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
        logic bit_wr;
    } eitp_bus_req_t;
endpackage

// ==== eitp_channel.sv ====
// One 8-bit interval timer channel with optional two-compare pwm
`timescale 1ns/1ps
`default_nettype none
module eitp_channel (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Control
    input wire logic count_pulse,
    input wire logic start_pulse,
    input wire logic count_run_bit,
    input wire logic pwm_mode,
    input wire logic [7:0] modulo_reg,
    input wire logic [7:0] high_period_modulo,
    // State
    output logic [7:0] count_reg,
    output logic match_irq,
    output logic toggle_flip_flop
);
    import eitp_pkg::*;

    logic [7:0] cnt_q;
    logic tff_q;
    logic phase_hi_q;
    logic [7:0] cmp_val;
    logic hit;

    // Compare target alternates between high and low periods in pwm mode
    assign cmp_val = (pwm_mode && phase_hi_q) ? high_period_modulo : modulo_reg; // R23
    assign hit = count_pulse && count_run_bit && !start_pulse && (cnt_q == cmp_val); // R9

    // Counter: start clears, run gates, match restarts from zero
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_q <= 8'h00;
        end else if (start_pulse) begin
            cnt_q <= 8'h00; // R13
        end else if (count_pulse && count_run_bit) begin // R14
            if (hit) begin
                cnt_q <= 8'h00; // R24 R4
            end else begin
                cnt_q <= cnt_q + 8'h01; // R9
            end
        end
    end

    // Output flip-flop inverts on every match, cleared on start
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tff_q <= 1'b0;
        end else if (start_pulse) begin
            tff_q <= 1'b0;
        end else if (hit) begin
            tff_q <= ~tff_q; // R9 R23
        end
    end

    // PWM phase: begins on the high period after each start
    always_ff @(posedge core_clk) begin
        if (rst) begin
            phase_hi_q <= 1'b1;
        end else if (start_pulse) begin
            phase_hi_q <= 1'b1;
        end else if (hit && pwm_mode) begin
            phase_hi_q <= ~phase_hi_q; // R23
        end
    end

    // Only the low-period compare raises the interrupt in pwm mode
    assign match_irq = hit && !(pwm_mode && phase_hi_q); // R5 R23
    assign count_reg = cnt_q;
    assign toggle_flip_flop = tff_q;

    chk_no_count_when_stopped: assert property (@(posedge core_clk) disable iff (rst) // R14
        !count_run_bit && !start_pulse |=> cnt_q == $past(cnt_q))
        else $error("count moved while stopped");
    chk_match_wraps_zero: assert property (@(posedge core_clk) disable iff (rst) // R24
        hit |=> cnt_q == 8'h00)
        else $error("count did not restart after match");
    chk_match_flips_tff: assert property (@(posedge core_clk) disable iff (rst) // R9
        hit |=> tff_q != $past(tff_q))
        else $error("toggle flip-flop missed a match");
    chk_pwm_high_no_irq: assert property (@(posedge core_clk) disable iff (rst) // R23
        pwm_mode && phase_hi_q |-> !match_irq)
        else $error("irq on high-period compare");
    cov_pwm_both_phases: cover property (@(posedge core_clk) disable iff (rst)
        pwm_mode && hit && phase_hi_q ##[1:600] pwm_mode && hit && !phase_hi_q);
endmodule
`default_nettype wire

// ==== eitp_timer.sv ====
// Top of the three-channel 8-bit interval timer with register port
// What the document asks of this block and its software
// R1: Control register writes as byte, nibble or bit; resets to 00H.
// R2: Software keeps control flags unused in 8-bit mode at zero.
// R3: Channel-2 pin low when its output enable is 0, else follows flip-flop.
// R4: Interval equals modulo plus one count pulses; zero modulo excluded.
// R5: Started channel sets its irq flag once per interval.
// R6: Modulo registers are 8 bits; FFH gives 256 pulses.
// R7: Channels 1 and 2 run independently when both mode fields are 0.
// R8: Channel-2 pulse select 010..111 gives fx/2, fx, /1024, /256, /64, /16.
// R9: Each pulse advances count; match sets irq and inverts flip-flop.
// R10: Software loads modulo first, then writes mode with start.
// R11: Software never writes a zero modulo.
// R12: Software prepares port 3 before setting output enable.
// R13: Writing start 1 clears counter and irq; run bit gates counting.
// R14: Run bit 0 halts and holds count; 1 counts.
// R15: Start bit writable alone, self-clears; other mode bits byte-only.
// R16: Channel-2 mode register resets to 00H.
// R17: Mode field 01 makes channel 2 an 8-bit pwm generator.
// R18: Software clears channel-1 mode bits while channel 2 is pwm.
// R19: Channels 0 and 1 stay usable as timers during pwm.
// R20: Software zeros control flags unused in pwm mode.
// R21: Channel-0 codes 100..111 give /1024, /256, /64, /16; others prohibited.
// R22: Channel-1 code 010 counts channel-2 overflow; 011..111 give /32../64.
// R23: PWM alternates high and low compares; only low sets irq.
// R24: After a match the count restarts from zero at next pulse.
// R25: A prohibited pulse code gives no count pulses.
`timescale 1ns/1ps
`default_nettype none
module eitp_timer (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register port
    input wire eitp_pkg::eitp_bus_req_t bus_req,
    output logic [7:0] rdata,
    // Timer output pins and irq flags
    output logic [2:0] timer_out_pin,
    output logic [2:0] timer_irq_flag
);
    import eitp_pkg::*;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] mode_q [3];
    logic [7:0] mod_q [3];
    logic [7:0] hmod_q;
    logic [7:0] ctrl_q;
    logic [1:0] oe01_q;
    logic [2:0] irq_q;
    logic [2:0] start_q;
    logic [7:0] rdata_q;
    logic [EITP_PRESCALE_W-1:0] pre_q;
    logic [EITP_PRESCALE_W-1:0] pre_prev_q;
    logic [2:0] cp;
    logic [2:0] hit;
    logic [2:0] tff;
    logic [7:0] cnt [3];
    logic [2:0] mode_wr;
    logic [2:0] mod_wr;
    logic [2:0] start_bit_wr;
    logic ctrl_wr;
    logic [2:0] status_clr;

    // Address decode for per-channel registers
    always_comb begin
        mode_wr = 3'b000;
        mod_wr = 3'b000;
        start_bit_wr = 3'b000;
        if (bus_req.wr) begin
            mode_wr[0] = bus_req.addr == EITP_ADDR_CH0_MODE;
            mode_wr[1] = bus_req.addr == EITP_ADDR_CH1_MODE;
            mode_wr[2] = bus_req.addr == EITP_ADDR_CH2_MODE;
            mod_wr[0] = bus_req.addr == EITP_ADDR_CH0_MOD;
            mod_wr[1] = bus_req.addr == EITP_ADDR_CH1_MOD;
            mod_wr[2] = bus_req.addr == EITP_ADDR_CH2_MOD;
        end
        // Single-bit start writes use a dedicated address with a channel mask
        if (bus_req.wr && bus_req.addr == EITP_ADDR_START) begin
            start_bit_wr = bus_req.wdata[2:0]; // R15
        end
    end

    // Control and status strobes, kept apart from the per-channel decode
    assign ctrl_wr = bus_req.wr && (bus_req.addr == EITP_ADDR_CTRL);
    assign status_clr = (bus_req.wr && bus_req.addr == EITP_ADDR_STATUS) ? bus_req.wdata[2:0] : 3'b000;

    // ----------------------------------------
    // Mode registers; start bit self-clears one cycle after it is seen
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < 3; i++) begin
            if (rst) begin
                mode_q[i] <= EITP_MODE_RESET; // R16
            end else if (mode_wr[i] && !bus_req.bit_wr) begin
                mode_q[i] <= {1'b0, bus_req.wdata[6:0]}; // R15
            end else if (start_bit_wr[i]) begin
                mode_q[i][EITP_BIT_START] <= 1'b1; // R15
            end else if (mode_q[i][EITP_BIT_START]) begin
                mode_q[i][EITP_BIT_START] <= 1'b0; // R15
            end
        end
    end

    // Start strobe seen by each channel while the command bit stands
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            start_q[i] = mode_q[i][EITP_BIT_START]; // R13
        end
    end

    // Modulo registers, full 8 bits each
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < 3; i++) begin
            if (rst) begin
                mod_q[i] <= EITP_MOD_RESET;
            end else if (mod_wr[i]) begin
                mod_q[i] <= bus_req.wdata; // R6
            end
        end
    end

    // High-period modulo for channel 2 pwm
    always_ff @(posedge core_clk) begin
        if (rst) begin
            hmod_q <= EITP_MOD_RESET;
        end else if (bus_req.wr && bus_req.addr == EITP_ADDR_CH2_HMOD) begin
            hmod_q <= bus_req.wdata; // R17
        end
    end

    // Control register: whole byte, or one bit (index wdata[6:4], value wdata[0])
    // Nibble writes reach this port as byte writes; bit 7 always stays 0
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_q <= EITP_CTRL_RESET; // R1
        end else if (ctrl_wr && !bus_req.bit_wr) begin
            ctrl_q <= {1'b0, bus_req.wdata[6:0]}; // R1
        end else if (ctrl_wr && bus_req.wdata[6:4] != 3'h7) begin
            ctrl_q[bus_req.wdata[6:4]] <= bus_req.wdata[0]; // R1
        end
    end

    // Output enables of channels 0 and 1
    always_ff @(posedge core_clk) begin
        if (rst) begin
            oe01_q <= 2'b00;
        end else if (bus_req.wr && bus_req.addr == EITP_ADDR_OUT_EN) begin
            oe01_q <= bus_req.wdata[1:0];
        end
    end

    // ----------------------------------------
    // Prescaler: one free counter, pulses on bit falling edges
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pre_q <= '0;
            pre_prev_q <= '0;
        end else begin
            pre_q <= pre_q + 1'b1;
            pre_prev_q <= pre_q;
        end
    end

    // Divide by 2^k pulse: bit k-1 fell
    function automatic logic div_tick(input int k);
        div_tick = pre_prev_q[k-1] && !pre_q[k-1];
    endfunction

    // Count pulse decode per channel; prohibited codes give nothing
    always_comb begin
        cp = 3'b000; // R25
        case (mode_q[0][6:4])
            3'b100: cp[0] = div_tick(10); // R21
            3'b101: cp[0] = div_tick(8);
            3'b110: cp[0] = div_tick(6);
            3'b111: cp[0] = div_tick(4);
            default: cp[0] = 1'b0; // R25
        endcase
        case (mode_q[1][6:4])
            3'b010: cp[1] = hit[2]; // R22
            3'b011: cp[1] = div_tick(5);
            3'b100: cp[1] = div_tick(12);
            3'b101: cp[1] = div_tick(10);
            3'b110: cp[1] = div_tick(8);
            3'b111: cp[1] = div_tick(6);
            default: cp[1] = 1'b0;
        endcase
        case (mode_q[2][6:4])
            3'b010: cp[2] = div_tick(1); // R8
            3'b011: cp[2] = 1'b1;
            3'b100: cp[2] = div_tick(10);
            3'b101: cp[2] = div_tick(8);
            3'b110: cp[2] = div_tick(6);
            3'b111: cp[2] = div_tick(4);
            default: cp[2] = 1'b0;
        endcase
    end

    // ----------------------------------------
    // Channels: each independent in 8-bit mode, except channel 1 on pulse code 010 counting channel-2 matches
    // ----------------------------------------
    for (genvar g = 0; g < 3; g++) begin : g_ch // R7 R19
        eitp_channel u_ch (
            .core_clk(core_clk),
            .rst(rst),
            .count_pulse(cp[g]),
            .start_pulse(start_q[g]),
            .count_run_bit(mode_q[g][EITP_BIT_RUN]), // R14
            .pwm_mode((g == 2) && (eitp_mode_t'(mode_q[g][1:0]) == EITP_MODE_PWM)), // R17
            .modulo_reg(mod_q[g]),
            .high_period_modulo(hmod_q),
            .count_reg(cnt[g]),
            .match_irq(hit[g]),
            .toggle_flip_flop(tff[g])
        );
    end

    // IRQ flags: match sets, start clears, set wins over a clear
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_q <= 3'b000;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (hit[i]) begin
                    irq_q[i] <= 1'b1; // R5 R9
                end else if (start_q[i] || status_clr[i]) begin
                    irq_q[i] <= 1'b0; // R13
                end
            end
        end
    end

    // Pins held low when disabled
    assign timer_out_pin[0] = oe01_q[0] & tff[0];
    assign timer_out_pin[1] = oe01_q[1] & tff[1];
    assign timer_out_pin[2] = ctrl_q[EITP_BIT_CTRL_OE2] & tff[2]; // R3
    assign timer_irq_flag = irq_q;

    // ----------------------------------------
    // Read data, one cycle after the strobe; unmapped reads zero
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                EITP_ADDR_CH0_MODE: rdata_q <= mode_q[0];
                EITP_ADDR_CH1_MODE: rdata_q <= mode_q[1];
                EITP_ADDR_CH2_MODE: rdata_q <= mode_q[2];
                EITP_ADDR_CH0_MOD: rdata_q <= mod_q[0];
                EITP_ADDR_CH1_MOD: rdata_q <= mod_q[1];
                EITP_ADDR_CH2_MOD: rdata_q <= mod_q[2];
                EITP_ADDR_CH2_HMOD: rdata_q <= hmod_q;
                EITP_ADDR_CTRL: rdata_q <= ctrl_q;
                EITP_ADDR_OUT_EN: rdata_q <= {6'h00, oe01_q};
                EITP_ADDR_CH0_CNT: rdata_q <= cnt[0];
                EITP_ADDR_CH1_CNT: rdata_q <= cnt[1];
                EITP_ADDR_CH2_CNT: rdata_q <= cnt[2];
                EITP_ADDR_STATUS: rdata_q <= {2'b00, tff, irq_q};
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign rdata = rdata_q;

    // ----------------------------------------
    // Interval monitor for full-rate 8-bit runs on channel 2
    // ----------------------------------------
    // Top value marks an interval spoiled by a rewrite or a stop
    logic [8:0] gap_q;
    logic gap_spoil;
    assign gap_spoil = mod_wr[2] || !mode_q[2][EITP_BIT_RUN] ||
        mode_q[2][6:4] != 3'b011 || mode_q[2][1:0] != 2'b00;
    always_ff @(posedge core_clk) begin
        if (rst || gap_spoil) begin
            gap_q <= 9'h1ff;
        end else if (start_q[2] || hit[2]) begin
            gap_q <= 9'h000;
        end else if (gap_q != 9'h1ff) begin
            gap_q <= gap_q + 9'h001;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_pin_low_disabled: assert property (@(posedge core_clk) disable iff (rst) // R3
        !ctrl_q[EITP_BIT_CTRL_OE2] |-> !timer_out_pin[2])
        else $error("channel 2 pin not low while disabled");
    chk_start_self_clears: assert property (@(posedge core_clk) disable iff (rst) // R15
        start_q[2] && !start_bit_wr[2] && !mode_wr[2] |=> !mode_q[2][EITP_BIT_START])
        else $error("start bit did not clear");
    chk_start_clears_irq: assert property (@(posedge core_clk) disable iff (rst) // R13
        start_q[0] |=> !irq_q[0])
        else $error("start did not clear irq");
    chk_irq_on_match: assert property (@(posedge core_clk) disable iff (rst) // R5
        hit[1] |=> irq_q[1])
        else $error("irq not set on match");
    chk_bad_code_idle: assert property (@(posedge core_clk) disable iff (rst) // R25
        mode_q[0][6:4] < 3'b100 |-> !cp[0])
        else $error("prohibited code produced pulse");
    chk_fx_every_cycle: assert property (@(posedge core_clk) disable iff (rst) // R8
        mode_q[2][6:4] == 3'b011 |-> cp[2])
        else $error("oscillator code missed pulse");
    chk_half_rate: assert property (@(posedge core_clk) disable iff (rst) // R8
        mode_q[2][6:4] == 3'b010 && cp[2] |=> !cp[2] || mode_q[2][6:4] != 3'b010)
        else $error("half rate pulse too dense");
    chk_ctrl_reset: assert property (@(posedge core_clk) // R1
        $past(rst) |-> ctrl_q == EITP_CTRL_RESET && mode_q[2] == EITP_MODE_RESET)
        else $error("reset value wrong");
    // Interval, flag and bus-side checks on channel 2
    chk_interval_len: assert property (@(posedge core_clk) disable iff (rst) // R4
        hit[2] && gap_q != 9'h1ff |-> gap_q == {1'b0, mod_q[2]})
        else $error("channel 2 interval length wrong");
    chk_pin_follows_tff: assert property (@(posedge core_clk) disable iff (rst) // R3
        ctrl_q[EITP_BIT_CTRL_OE2] |-> timer_out_pin[2] == tff[2])
        else $error("channel 2 pin not following flip-flop");
    chk_ctrl_bit_write: assert property (@(posedge core_clk) disable iff (rst) // R1
        ctrl_wr && bus_req.bit_wr && bus_req.wdata[6:4] == 3'h3 |=> ctrl_q[3] == $past(bus_req.wdata[0]))
        else $error("control bit write lost");
    chk_mod_write: assert property (@(posedge core_clk) disable iff (rst) // R6
        mod_wr[2] |=> mod_q[2] == $past(bus_req.wdata))
        else $error("modulo write lost");
    chk_mode_byte_only: assert property (@(posedge core_clk) disable iff (rst) // R15
        mode_wr[2] && bus_req.bit_wr && !mode_q[2][EITP_BIT_START] |=> $stable(mode_q[2]))
        else $error("bit access changed mode byte");
    chk_irq_sticky: assert property (@(posedge core_clk) disable iff (rst) // R5
        irq_q[2] && !start_q[2] && !status_clr[2] |=> irq_q[2])
        else $error("irq flag dropped on its own");
    chk_ch2_irq_on_match: assert property (@(posedge core_clk) disable iff (rst) // R9
        hit[2] |=> irq_q[2])
        else $error("channel 2 irq not set on match");
    chk_start_clears_cnt: assert property (@(posedge core_clk) disable iff (rst) // R13
        start_q[2] |=> cnt[2] == 8'h00)
        else $error("start did not clear count");
    cov_ch2_match: cover property (@(posedge core_clk) disable iff (rst) hit[2]);
    cov_ch1_cascade: cover property (@(posedge core_clk) disable iff (rst) hit[2] && mode_q[1][6:4] == 3'b010);
    cov_pin_toggle: cover property (@(posedge core_clk) disable iff (rst) $rose(timer_out_pin[2]));
    cov_full_interval: cover property (@(posedge core_clk) disable iff (rst) hit[2] && gap_q == 9'h0ff);
endmodule
`default_nettype wire

// ==== eitp_pin_load.sv ====
// Pin load model that times the level changes seen on the three timer pins
`timescale 1ns/1ps
`default_nettype none
module eitp_pin_load (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Pins seen by the load
    input wire logic [2:0] timer_out_pin,
    // Spacing in cycles of the last two pin edges, per pin
    output logic [2:0][15:0] last_q,
    output logic [2:0][15:0] prev_q
);
    logic [2:0][15:0] run_q;
    logic [2:0] pin_q;

    // Purely sensing load: it never drives the pins, it only measures them
    always_ff @(posedge core_clk) begin
        if (rst) begin
            last_q <= '0;
            prev_q <= '0;
            run_q <= '0;
            pin_q <= 3'h0;
        end else begin
            pin_q <= timer_out_pin;
            for (int i = 0; i < 3; i++) begin
                if (timer_out_pin[i] !== pin_q[i]) begin
                    prev_q[i] <= last_q[i];
                    last_q[i] <= run_q[i] + 16'h0001;
                    run_q[i] <= 16'h0000;
                end else begin
                    run_q[i] <= run_q[i] + 16'h0001;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb_eitp_timer.sv ====
// Self-checking testbench for the three-channel interval timer
`timescale 1ns/1ps
`default_nettype none
module tb_eitp_timer;
    import eitp_pkg::*;
    logic core_clk;
    logic rst;
    eitp_bus_req_t bus_req;
    logic [7:0] rdata;
    logic [2:0] timer_out_pin;
    logic [2:0] timer_irq_flag;
    logic [2:0][15:0] last_q;
    logic [2:0][15:0] prev_q;
    logic [7:0] v;
    logic [7:0] w;
    int err_count;
    int samples_checked;
    // Legal channel-2 pulse codes and their divide ratios
    logic [2:0] code_tab [6] = '{3'b010, 3'b011, 3'b100, 3'b101, 3'b110, 3'b111};
    logic [15:0] div_tab [6] = '{16'd2, 16'd1, 16'd1024, 16'd256, 16'd64, 16'd16};

    eitp_timer dut (
        .core_clk(core_clk),
        .rst(rst),
        .bus_req(bus_req),
        .rdata(rdata),
        .timer_out_pin(timer_out_pin),
        .timer_irq_flag(timer_irq_flag)
    );

    eitp_pin_load load (
        .core_clk(core_clk),
        .rst(rst),
        .timer_out_pin(timer_out_pin),
        .last_q(last_q),
        .prev_q(prev_q)
    );

    // 50 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        #1;
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe; bit_wr marks a single-bit access
    task automatic bus_wr(input logic [11:0] a, input logic [7:0] d, input logic bw);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, bit_wr: bw};
        @(posedge core_clk);
        bus_req <= '0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1, bit_wr: 1'b0};
        @(posedge core_clk);
        bus_req <= '0;
        #1;
        d = rdata;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
        bus_rd(a, v);
        check({8'h00, v}, {8'h00, exp});
    endtask

    // Mode byte: pulse code, start and run set, mode field
    function automatic logic [7:0] mbyte(input logic [2:0] code, input logic [1:0] mode);
        return {1'b0, code, 2'b11, mode};
    endfunction

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Watchdog well beyond the longest sequence below
    initial begin
        repeat (30000) @(posedge core_clk);
        err_count++;
        end_of_test();
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        bus_req = '0;
        rst = 1'b1;
        err_count = 0;
        samples_checked = 0;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        rd_chk(EITP_ADDR_CH2_MODE, 8'h00);
        rd_chk(EITP_ADDR_CTRL, 8'h00);
        rd_chk(EITP_ADDR_CH2_MOD, EITP_MOD_RESET);
        rd_chk(12'hf00, 8'h00);
        bus_wr(EITP_ADDR_CTRL, 8'h88, 1'b0);
        rd_chk(EITP_ADDR_CTRL, 8'h08);
        bus_wr(EITP_ADDR_CTRL, 8'h30, 1'b1);
        rd_chk(EITP_ADDR_CTRL, 8'h00);
        bus_wr(EITP_ADDR_CTRL, 8'h00, 1'b0);
        // Full-rate interval of four pulses; modulo loaded before the mode
        bus_wr(EITP_ADDR_CH2_MOD, 8'h03, 1'b0);
        bus_wr(EITP_ADDR_CH2_MODE, mbyte(3'b011, 2'b00), 1'b0);
        repeat (20) @(posedge core_clk);
        check({15'h0000, timer_out_pin[2]}, 16'h0000);
        check({15'h0000, timer_irq_flag[2]}, 16'h0001);
        bus_wr(EITP_ADDR_CTRL, 8'h08, 1'b0);
        repeat (20) @(posedge core_clk);
        check(last_q[2], 16'd4);
        // Longest interval
        bus_wr(EITP_ADDR_CH2_MOD, 8'hff, 1'b0);
        bus_wr(EITP_ADDR_CH2_MODE, mbyte(3'b011, 2'b00), 1'b0);
        repeat (800) @(posedge core_clk);
        check(last_q[2], 16'd256);
        // Every legal pulse code with a two-pulse interval
        bus_wr(EITP_ADDR_CH2_MOD, 8'h01, 1'b0);
        for (int i = 0; i < 6; i++) begin
            bus_wr(EITP_ADDR_CH2_MODE, mbyte(code_tab[i], 2'b00), 1'b0);
            repeat (6 * div_tab[i] + 20) @(posedge core_clk);
            check(last_q[2], div_tab[i] << 1);
        end
        // Run bit low freezes the count where it stands
        bus_wr(EITP_ADDR_CH2_MOD, 8'hff, 1'b0);
        bus_wr(EITP_ADDR_CH2_MODE, mbyte(3'b011, 2'b00), 1'b0);
        repeat (50) @(posedge core_clk);
        bus_wr(EITP_ADDR_CH2_MODE, 8'h30, 1'b0);
        bus_rd(EITP_ADDR_CH2_CNT, w);
        repeat (10) @(posedge core_clk);
        rd_chk(EITP_ADDR_CH2_CNT, w);
        check({8'h00, w}, 16'h0033);
        // Start without run clears count, flags and itself
        bus_wr(EITP_ADDR_CH2_MODE, 8'h38, 1'b0);
        rd_chk(EITP_ADDR_CH2_CNT, 8'h00);
        rd_chk(EITP_ADDR_STATUS, 8'h00);
        rd_chk(EITP_ADDR_CH2_MODE, 8'h30);
        bus_wr(EITP_ADDR_CH2_MODE, 8'h7c, 1'b1);
        rd_chk(EITP_ADDR_CH2_MODE, 8'h30);
        // A prohibited pulse code leaves the counter still
        bus_wr(EITP_ADDR_CH2_MODE, mbyte(3'b000, 2'b00), 1'b0);
        repeat (20) @(posedge core_clk);
        rd_chk(EITP_ADDR_CH2_CNT, 8'h00);
        // Pulse generator on channel 2 beside two plain timers
        bus_wr(EITP_ADDR_CH2_HMOD, 8'h01, 1'b0);
        bus_wr(EITP_ADDR_CH2_MOD, 8'h02, 1'b0);
        bus_wr(EITP_ADDR_CH2_MODE, mbyte(3'b011, 2'b01), 1'b0);
        bus_wr(EITP_ADDR_CH0_MOD, 8'h01, 1'b0);
        bus_wr(EITP_ADDR_CH0_MODE, mbyte(3'b111, 2'b00), 1'b0);
        bus_wr(EITP_ADDR_CH1_MOD, 8'h01, 1'b0);
        bus_wr(EITP_ADDR_CH1_MODE, mbyte(3'b011, 2'b00), 1'b0);
        bus_wr(EITP_ADDR_OUT_EN, 8'h03, 1'b0);
        repeat (300) @(posedge core_clk);
        check(last_q[2] + prev_q[2], 16'd5);
        check({15'h0000, last_q[2] !== prev_q[2]}, 16'h0001);
        check({15'h0000, timer_irq_flag[2]}, 16'h0001);
        check(last_q[0], 16'd32);
        check(last_q[1], 16'd64);
        // Start bit alone restarts channel 0: flag cleared, command bit gone
        check({15'h0000, timer_irq_flag[0]}, 16'h0001);
        bus_wr(EITP_ADDR_START, 8'h01, 1'b1);
        bus_rd(EITP_ADDR_STATUS, v);
        check({15'h0000, v[0]}, 16'h0000);
        rd_chk(EITP_ADDR_CH0_MODE, 8'h74);
        // Channel 1 counting channel 2 matches, three cycles apart
        bus_wr(EITP_ADDR_CH2_MODE, mbyte(3'b011, 2'b00), 1'b0);
        bus_wr(EITP_ADDR_CH1_MODE, mbyte(3'b010, 2'b00), 1'b0);
        repeat (100) @(posedge core_clk);
        check(last_q[1], 16'd6);
        end_of_test();
    end
endmodule
`default_nettype wire
